//--- hdl/radio_modem_config.v
// configuration registers, channel selection and transmit wait timer of a serial radio modem
// assumes a host register port already decoded from command mode, and a buffer fill count
// Functional notes
// RULE_01: wideband channels 0..31, narrowband channels 1..83 are accepted.
// RULE_02: certified narrowband: channel value zero selects channel 1.
// RULE_03: restricted wideband: 12..17 map to 18, 5..11 map to 4.
// RULE_04: restricted narrowband: 14..29 map to 13, 30..44 map to 45.
// RULE_05: separate transmit (0x4b) and receive (0x4c) channel registers, used independently.
// RULE_06: wideband mode uses only the low six channel bits.
// RULE_07: host should program equal transmit and receive channels.
// RULE_08: all nodes share mode family and channels to communicate.
// RULE_09: three-bit power code picks band family and power level.
// RULE_10: any wideband setting hears any wideband; families never hear each other.
// RULE_11: low three baud bits select the serial rate; upper bits reserved.
// RULE_12: baud rate defaults to the 2400 setting.
// RULE_13: reset with command pin low returns baud to 2400.
// RULE_14: role value 0x00 is slave, any other (0x01, 0x80) is normal.
// RULE_15: slave nodes exchange frames only with normal nodes.
// RULE_16: each host byte reloads the wait timer, which counts down per millisecond.
// RULE_17: timer reaching zero starts transmission of buffered bytes.
// RULE_18: timeout 0x00 disables timer; send only at full threshold.
// RULE_19: wait timeout resets to 0x10, about sixteen milliseconds.
// RULE_20: host should program timeout above 0x01 and over one character time.
// RULE_21: send threshold 1..144 triggers transmission, default 64.
// RULE_22: command pin low at reset release restores factory settings.
// RULE_23: timeout is eight bits in one-millisecond units from a system tick.
// RULE_24: aliasing applied after masking; stored register value unchanged.
`timescale 1ns/1ps
`include "radio_modem_map.vh"
module radio_modem_config #(
   parameter CERTIFIED  = 1,
   parameter RESTRICTED = 0,
   parameter TICK_COUNT = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire       sys_clk,
   input  wire       reset,
   // command pin from host, asynchronous
   input  wire       command_pin_n,
   // register port in command mode
   input  wire       reg_write,
   input  wire       reg_read,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_ack,
   // serial byte arrivals and buffer state
   input  wire       host_byte_strobe,
   input  wire [7:0] buffered_count,
   output reg        start_transmit,
   // decoded configuration
   output reg  [6:0] tx_channel_eff,
   output reg  [6:0] rx_channel_eff,
   output wire       wideband_mode,
   output wire       narrowband_mode,
   output wire [1:0] power_level,
   output wire [2:0] baud_code,
   output wire       slave_role,
   // peer frame filter
   input  wire       peer_wideband,
   input  wire       peer_is_slave,
   output wire       peer_accept
);

   // saved copies are non-volatile: reset leaves them alone, the initial value
   // stands for the factory programming, and only a pin-low restore or a write moves them
   reg [7:0] baud_select_saved  = `RST_BAUD;
   reg [7:0] network_role_saved = `RST_ROLE;
   reg [7:0] transmit_channel;
   reg [7:0] receive_channel;
   reg [7:0] baud_select_live;
   reg [7:0] network_role_live;
   reg [7:0] rf_power_mode_select;
   reg [7:0] tx_wait_timeout;
   reg [7:0] send_threshold_bytes;

   // command pin sync
   reg       cmd_meta;
   reg       cmd_sync;
   reg [1:0] settle;   // edges since reset release, saturates at 3

   // timer
   reg [19:0] tick_div;
   reg        ms_tick;
   reg [7:0]  wait_count;
   reg        wait_armed;

   // channel mapping, mask first then alias, stored values untouched
   function [6:0] map_channel;
      input [7:0] raw;
      input       wide;
      reg   [7:0] ch;
      begin
         ch = wide ? (raw & `CHAN_MASK_WIDE) : raw;                     // see RULE_06, RULE_24
         if (!wide && CERTIFIED != 0 && ch == 8'h00)
            ch = 8'h01;                                                  // see RULE_02
         if (RESTRICTED != 0) begin
            if (wide) begin
               if (ch >= 8'h0c && ch <= 8'h11)
                  ch = 8'h12;                                            // see RULE_03
               else if (ch >= 8'h05 && ch <= 8'h0b)
                  ch = 8'h04;
            end else begin
               if (ch >= 8'h0e && ch <= 8'h1d)
                  ch = 8'h0d;                                            // see RULE_04
               else if (ch >= 8'h1e && ch <= 8'h2c)
                  ch = 8'h2d;
            end
         end
         // out of range requests clamp to the top channel
         if (wide && ch > 8'h1f)
            ch = 8'h1f;                                                  // see RULE_01
         else if (!wide && ch > 8'h53)
            ch = 8'h53;
         map_channel = ch[6:0];
      end
   endfunction

   // power code: 000 and 101..111 narrowband, 001..100 wideband
   assign wideband_mode   = (rf_power_mode_select[2:0] >= 3'h1) &&
                            (rf_power_mode_select[2:0] <= 3'h4);        // see RULE_09
   assign narrowband_mode = !wideband_mode;
   assign power_level     = (rf_power_mode_select[2:0] == 3'h0 ||
                             rf_power_mode_select[2:0] == 3'h4) ? 2'h0 :
                            rf_power_mode_select[1:0];
   assign baud_code  = baud_select_live[`BAUD_FIELD_MSB:`BAUD_FIELD_LSB]; // see RULE_11
   assign slave_role = (network_role_live == `ROLE_SLAVE);             // see RULE_14
   // family must match; two slaves never talk
   assign peer_accept = (peer_wideband == wideband_mode) &&             // see RULE_10
                        !(slave_role && peer_is_slave);                  // see RULE_15

   // effective channels, one per direction
   always @(posedge sys_clk) begin
      if (reset) begin
         tx_channel_eff <= 7'h00;
         rx_channel_eff <= 7'h00;
      end else begin
         tx_channel_eff <= map_channel(transmit_channel, wideband_mode); // see RULE_05
         rx_channel_eff <= map_channel(receive_channel, wideband_mode);
      end
   end

   // command pin synchroniser; first flop feeds only the second
   always @(posedge sys_clk) begin
      if (reset) begin
         cmd_meta    <= 1'b1;
         cmd_sync    <= 1'b1;
         settle      <= 2'h0;
      end else begin
         cmd_meta    <= command_pin_n;
         cmd_sync    <= cmd_meta;
         // stage two holds the pin as seen at the first edge after release by count 2
         if (settle != 2'h3)
            settle <= settle + 2'h1;
      end
   end

   // register file; factory restore sampled just after reset release
   always @(posedge sys_clk) begin
      if (reset) begin
         transmit_channel     <= `RST_CHAN;
         receive_channel      <= `RST_CHAN;
         baud_select_live     <= `RST_BAUD;                              // see RULE_12
         network_role_live    <= `RST_ROLE;
         rf_power_mode_select <= `RST_POWER;
         tx_wait_timeout      <= `RST_TIMEOUT;                           // see RULE_19
         send_threshold_bytes <= `RST_THRESHOLD;                         // see RULE_21
      end else if (settle == 2'h2 && !cmd_sync) begin
         // one look only, third edge after release; a write in that cycle is lost
         baud_select_saved  <= `RST_BAUD;                                // see RULE_13, RULE_22
         baud_select_live   <= `RST_BAUD;
         network_role_saved <= `RST_ROLE;
         network_role_live  <= `RST_ROLE;
      end else if (reg_write) begin
         case (reg_addr)
            `OFS_BAUD_SAVED:     baud_select_saved    <= {5'h00, reg_wdata[2:0]};
            `OFS_ROLE_SAVED:     network_role_saved   <= reg_wdata;
            `OFS_TX_CHAN:        transmit_channel     <= reg_wdata;
            `OFS_RX_CHAN:        receive_channel      <= reg_wdata;
            `OFS_BAUD_LIVE:      baud_select_live     <= {5'h00, reg_wdata[2:0]};
            `OFS_ROLE_LIVE:      network_role_live    <= reg_wdata;
            `OFS_POWER_MODE:     rf_power_mode_select <= {5'h00, reg_wdata[2:0]};
            `OFS_TX_TIMEOUT:     tx_wait_timeout      <= reg_wdata;      // see RULE_23
            `OFS_SEND_THRESHOLD: begin
               // out of range writes are ignored to keep 1..144
               if (reg_wdata != 8'h00 && reg_wdata <= `THRESHOLD_MAX)
                  send_threshold_bytes <= reg_wdata;                     // see RULE_21
            end
            default: ;
         endcase
      end
   end

   // read port, one cycle answer; unmapped reads zero
   always @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_ack   <= 1'b0;
      end else begin
         reg_ack <= reg_read | reg_write;
         if (reg_read) begin
            case (reg_addr)
               `OFS_BAUD_SAVED:     reg_rdata <= baud_select_saved;
               `OFS_ROLE_SAVED:     reg_rdata <= network_role_saved;
               `OFS_TX_CHAN:        reg_rdata <= transmit_channel;
               `OFS_RX_CHAN:        reg_rdata <= receive_channel;
               `OFS_BAUD_LIVE:      reg_rdata <= baud_select_live;
               `OFS_ROLE_LIVE:      reg_rdata <= network_role_live;
               `OFS_POWER_MODE:     reg_rdata <= rf_power_mode_select;
               `OFS_TX_TIMEOUT:     reg_rdata <= tx_wait_timeout;
               `OFS_SEND_THRESHOLD: reg_rdata <= send_threshold_bytes;
               default:             reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // millisecond tick divider
   always @(posedge sys_clk) begin
      if (reset) begin
         tick_div <= 20'h00000;
         ms_tick  <= 1'b0;
      end else if (tick_div == TICK_COUNT - 1) begin
         tick_div <= 20'h00000;
         ms_tick  <= 1'b1;
      end else begin
         tick_div <= tick_div + 20'h00001;
         ms_tick  <= 1'b0;
      end
   end

   // wait timer and transmit trigger; a byte beats a same-cycle tick
   always @(posedge sys_clk) begin
      if (reset) begin
         wait_count     <= 8'h00;
         wait_armed     <= 1'b0;
         start_transmit <= 1'b0;
      end else begin
         start_transmit <= 1'b0;
         if (buffered_count >= send_threshold_bytes) begin
            start_transmit <= 1'b1;                                      // see RULE_18, RULE_21
            wait_armed     <= 1'b0;
         end else if (host_byte_strobe) begin
            wait_count <= tx_wait_timeout;                               // see RULE_16
            wait_armed <= (tx_wait_timeout != 8'h00);                    // see RULE_18
         end else if (wait_armed && ms_tick) begin
            if (wait_count <= 8'h01) begin
               wait_count     <= 8'h00;
               wait_armed     <= 1'b0;
               start_transmit <= (buffered_count != 8'h00);              // see RULE_17
            end else begin
               wait_count <= wait_count - 8'h01;                         // see RULE_16
            end
         end
      end
   end

endmodule

//--- hdl/radio_modem_map.vh
// register offsets, reset values and timing counts for the radio modem configuration block
// assumes inclusion by the design file and the bench top; definitions only
`ifndef RADIO_MODEM_MAP_VH
`define RADIO_MODEM_MAP_VH
`define OFS_BAUD_SAVED      8'h03
`define OFS_ROLE_SAVED      8'h04
`define OFS_TX_CHAN         8'h4b
`define OFS_RX_CHAN         8'h4c
`define OFS_BAUD_LIVE       8'h4e
`define OFS_ROLE_LIVE       8'h4f
`define OFS_POWER_MODE      8'h50
`define OFS_TX_TIMEOUT      8'h57
`define OFS_SEND_THRESHOLD  8'h54
`define RST_BAUD            8'h00
`define RST_ROLE            8'h01
`define RST_CHAN            8'h00
`define RST_POWER           8'h04
`define RST_TIMEOUT         8'h10
`define RST_THRESHOLD       8'h40
`define THRESHOLD_MAX       8'h90
`define ROLE_SLAVE          8'h00
`define CHAN_MASK_WIDE      8'h3f
`define BAUD_FIELD_LSB      0
`define BAUD_FIELD_MSB      2
`define TICK_PERIOD_NS      1000000
`define CLK_PERIOD_NS       40
`endif

//--- testbench/radio_modem_config_chk.sv
// port assertions for the radio modem configuration block
// assumes bind into radio_modem_config, one clock, sync reset
`timescale 1ns/1ps
module radio_modem_config_chk (
   // clock and reset
   input wire       sys_clk,
   input wire       reset,
   // register port
   input wire       reg_write,
   input wire       reg_read,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_ack,
   // transmit trigger
   input wire [7:0] buffered_count,
   input wire       start_transmit,
   // decoded settings
   input wire [6:0] tx_channel_eff,
   input wire       wideband_mode,
   input wire       narrowband_mode,
   input wire [2:0] baud_code,
   input wire       slave_role
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   ack_after_req_a: assert property ((reg_write || reg_read) |=> reg_ack)
      else $error("request not acknowledged");
   ack_cause_a: assert property (reg_ack |-> $past(reg_write || reg_read))
      else $error("acknowledge without request");
   family_excl_a: assert property (wideband_mode != narrowband_mode)
      else $error("band family not exclusive");
   wide_chan_a: assert property ($past(wideband_mode) && wideband_mode |-> tx_channel_eff <= 7'd31)
      else $error("wideband channel out of range");
   narrow_chan_a: assert property ($past(narrowband_mode) && narrowband_mode |-> tx_channel_eff != 7'd0 && tx_channel_eff <= 7'd83)
      else $error("narrowband channel out of range");
   empty_no_tx_a: assert property (start_transmit |-> $past(buffered_count) != 8'h00)
      else $error("transmit with empty buffer");
   baud_write_a: assert property ($past(reg_write) && $past(reg_addr) == 8'h4e |-> baud_code == $past(reg_wdata[2:0]))
      else $error("baud code not taken");
   role_write_a: assert property ($past(reg_write) && $past(reg_addr) == 8'h4f |-> slave_role == ($past(reg_wdata) == 8'h00))
      else $error("role not taken");
   reset_baud_a: assert property ($fell(reset) |-> baud_code == 3'h0 && !slave_role)
      else $error("wrong settings after reset");
   // main scenarios reached
   cover property (start_transmit);
   cover property (narrowband_mode && tx_channel_eff == 7'd1);
   cover property (slave_role && reg_ack);
endmodule
bind radio_modem_config radio_modem_config_chk chk (.sys_clk(sys_clk), .reset(reset),
   .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_ack(reg_ack), .buffered_count(buffered_count), .start_transmit(start_transmit),
   .tx_channel_eff(tx_channel_eff), .wideband_mode(wideband_mode),
   .narrowband_mode(narrowband_mode), .baud_code(baud_code), .slave_role(slave_role));

//--- testbench/host_feeder.sv
// host side model: serial byte arrivals and buffer fill level
// assumes the buffer drains whenever a transmission starts
`timescale 1ns/1ps
module host_feeder (
   // clock
   input  wire       sys_clk,
   // request and block reply
   input  wire       send,
   input  wire       start_transmit,
   // byte arrival and buffer level
   output reg        host_byte_strobe = 1'b0,
   output reg  [7:0] buffered_count = 8'h00
);
   // one strobe per byte; a started transmission empties the buffer
   always @(posedge sys_clk) begin
      host_byte_strobe <= send;
      if (start_transmit)
         buffered_count <= 8'h00;
      else if (send)
         buffered_count <= buffered_count + 8'h01;
   end
endmodule

//--- testbench/radio_modem_config_tb_top.sv
// self-checking bench for the radio modem configuration block
// assumes a 10-cycle millisecond tick and the host_feeder model
`timescale 1ns/1ps
`include "radio_modem_map.vh"
module radio_modem_config_tb_top;
   reg        sys_clk = 1'b0;
   reg        reset = 1'b1;
   reg        command_pin_n = 1'b1; // high at power-up
   reg        reg_write = 1'b0;
   reg        reg_read = 1'b0;
   reg  [7:0] reg_addr = 8'h00;
   reg  [7:0] reg_wdata = 8'h00;
   reg        send = 1'b0;
   reg        peer_wideband = 1'b0;
   reg        peer_is_slave = 1'b0;
   wire [7:0] reg_rdata, buffered_count;
   wire       reg_ack, host_byte_strobe, start_transmit, slave_role, peer_accept;
   wire       wideband_mode, narrowband_mode;
   wire [6:0] tx_channel_eff, rx_channel_eff;
   wire [1:0] power_level;
   wire [2:0] baud_code;
   integer    failures = 0, n_tests = 0, i, n;
   reg  [7:0] v, d;
   always #20 sys_clk = ~sys_clk;
   radio_modem_config #(.TICK_COUNT(10)) dut (.sys_clk(sys_clk), .reset(reset),
      .command_pin_n(command_pin_n), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .host_byte_strobe(host_byte_strobe), .buffered_count(buffered_count),
      .start_transmit(start_transmit), .tx_channel_eff(tx_channel_eff),
      .rx_channel_eff(rx_channel_eff), .wideband_mode(wideband_mode),
      .narrowband_mode(narrowband_mode), .power_level(power_level), .baud_code(baud_code),
      .slave_role(slave_role), .peer_wideband(peer_wideband), .peer_is_slave(peer_is_slave),
      .peer_accept(peer_accept));
   host_feeder host (.sys_clk(sys_clk), .send(send), .start_transmit(start_transmit),
      .host_byte_strobe(host_byte_strobe), .buffered_count(buffered_count));
   task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp); begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
      end
   end endtask
   // one register cycle; ack may come a cycle late, so poll a few
   task bus(input w, input [7:0] a, input [7:0] dv); begin
      @(negedge sys_clk);
      reg_write = w;
      reg_read = !w;
      reg_addr = a;
      reg_wdata = dv;
      @(negedge sys_clk);
      reg_write = 1'b0;
      reg_read = 1'b0;
      n = 0;
      while (reg_ack !== 1'b1 && n < 3) begin
         @(negedge sys_clk);
         n = n + 1;
      end
      chk("ack", reg_ack, 8'h01);
      d = reg_rdata;
   end endtask
   task byte_in; begin
      @(negedge sys_clk);
      send = 1'b1;
      @(negedge sys_clk);
      send = 1'b0;
   end endtask
   // channel after mask, zero substitution and clamp
   function [7:0] ech(input [7:0] r, input wb); begin
      if (wb)
         ech = (r[5:0] > 6'd31) ? 8'd31 : {2'b00, r[5:0]};
      else
         ech = (r == 8'h00) ? 8'd1 : (r > 8'd83) ? 8'd83 : r;
   end endfunction
   task end_sim; begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end endtask
   initial begin
      #400000;
      failures = failures + 1;
      end_sim;
   end
   initial begin
      v = 8'($urandom(24629));
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      repeat (5) @(negedge sys_clk);
      bus(0, `OFS_BAUD_LIVE, 8'h00);
      chk("baud", d, `RST_BAUD);
      bus(0, `OFS_ROLE_LIVE, 8'h00);
      chk("role", d, `RST_ROLE);
      bus(0, `OFS_TX_TIMEOUT, 8'h00);
      chk("timeout", d, `RST_TIMEOUT);
      bus(0, 8'h77, 8'h00);
      chk("unmap", d, 8'h00);
      $display("test reset values done");
      for (i = 0; i < 8; i = i + 1) begin
         v = 8'($urandom);
         bus(1, `OFS_BAUD_LIVE, {v[7:3], i[2:0]});
         chk("baud", baud_code, i[2:0]);
         bus(1, `OFS_POWER_MODE, {v[7:3], i[2:0]});
         chk("wide", wideband_mode, i >= 1 && i <= 4);
         chk("narrow", narrowband_mode, i == 0 || i >= 5);
         chk("level", power_level, i[1:0]);
      end
      $display("test codes done");
      for (i = 0; i < 16; i = i + 1) begin
         v = (i < 2) ? {i[0], i[0], 6'h00} : 8'($urandom);
         bus(1, `OFS_POWER_MODE, {5'h00, i[0], 2'b00});
         bus(1, `OFS_TX_CHAN, v);
         bus(1, `OFS_RX_CHAN, ~v);
         @(negedge sys_clk);
         chk("txch", tx_channel_eff, ech(v, i[0]));
         chk("rxch", rx_channel_eff, ech(~v, i[0]));
         bus(0, `OFS_TX_CHAN, 8'h00);
         chk("txreg", d, v);
      end
      bus(1, `OFS_RX_CHAN, v); // equal channels as a network wants
      @(negedge sys_clk);
      chk("eqch", rx_channel_eff, ech(v, 1'b1));
      $display("test channels done");
      for (i = 0; i < 8; i = i + 1) begin
         peer_wideband = i[0];
         peer_is_slave = i[1];
         bus(1, `OFS_ROLE_LIVE, i[2] ? 8'h80 : 8'h00);
         chk("slave", slave_role, !i[2]);
         chk("peer", peer_accept, i[0] && !(i[1] && !i[2]));
      end
      $display("test roles done");
      bus(1, `OFS_TX_TIMEOUT, 8'h03); // above one tick
      bus(1, `OFS_SEND_THRESHOLD, 8'h90);
      bus(1, `OFS_SEND_THRESHOLD, 8'h91);
      bus(0, `OFS_SEND_THRESHOLD, 8'h00);
      chk("thresh", d, 8'h90);
      byte_in;
      repeat (15) @(negedge sys_clk);
      byte_in;
      n = 0;
      while (start_transmit !== 1'b1 && n < 60) begin
         @(negedge sys_clk);
         n = n + 1;
      end
      chk("wait", n >= 18 && n <= 33, 8'h01);
      bus(1, `OFS_TX_TIMEOUT, 8'h00);
      bus(1, `OFS_SEND_THRESHOLD, 8'h02);
      byte_in;
      n = 0;
      repeat (60) begin
         @(negedge sys_clk);
         n = n + start_transmit;
      end
      chk("idle", n, 8'h00);
      byte_in;
      @(negedge sys_clk);
      chk("full", start_transmit, 8'h01);
      $display("test timer done");
      bus(1, `OFS_BAUD_SAVED, 8'h05);
      reset = 1'b1;
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      repeat (6) @(negedge sys_clk);
      bus(0, `OFS_BAUD_SAVED, 8'h00);
      chk("kept", d, 8'h05);
      command_pin_n = 1'b0;
      reset = 1'b1;
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      repeat (6) @(negedge sys_clk);
      command_pin_n = 1'b1;
      bus(0, `OFS_BAUD_SAVED, 8'h00);
      chk("saved", d, `RST_BAUD);
      $display("test command reset done");
      end_sim;
   end
endmodule
